// ==== ibsf_consts.svh ====
// Functional notes
// - reset clears status to zero
// - after wakeup off, freeze until start/stop
// - bit order master..stop, seven down to zero
// - master flag one during master communication
// - master flag set when start generated
// - master flag cleared stop, loss, exit, disable
// - arbitration loss sets lost, clears master
// - lost flag cleared by read, disable, reset
// - ext flag set at 8th clock, 0000/1111
// - ext flag cleared start, stop, exit, disable
// - match flag set at 8th clock on match
// - match flag cleared start, stop, exit, disable
// - transmit flag one while driving data line
// - ack flag at 9th clock, cleared next byte
`ifndef IBSF_CONSTS_SVH
`define IBSF_CONSTS_SVH
`define IBSF_ADDR_STATUS 20'hFFF51
`define IBSF_ADDR_CTRL 20'hFFF60
`define IBSF_ADDR_IRQ_ST 20'hFFF61
`define IBSF_ADDR_IRQ_MASK 20'hFFF62
`define IBSF_ADDR_SLAVE 20'hFFF63
`define IBSF_STATUS_RST 8'h00
`define IBSF_CTRL_EXIT 0
`define IBSF_CTRL_START 1
`define IBSF_CTRL_TX 2
`define IBSF_CTRL_WAKE 3
`define IBSF_CTRL_ENABLE 7
`define IBSF_EV_START 0
`define IBSF_EV_STOP 1
`define IBSF_EV_ARB 2
`define IBSF_EV_ADDR 3
`define IBSF_BIT_ADDR 4'h8
`define IBSF_BIT_ACK 4'h9
`endif

// ==== ibsf_pkg.sv ====
package ibsf_pkg;
  typedef struct packed {
    logic master_state_flag;
    logic arb_lost_flag;
    logic ext_code_flag;
    logic addr_match_flag;
    logic tx_state_flag;
    logic ack_seen_flag;
    logic start_seen_flag;
    logic stop_seen_flag;
  } ibsf_status_t;
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ibsf_bus_t;
  typedef enum logic [1:0] {
    IBSF_IDLE = 2'b00,
    IBSF_ADDR = 2'b01,
    IBSF_DATA = 2'b10
  } ibsf_phase_t;
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_q;
    logic sda_q;
    ibsf_phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    ibsf_status_t status;
    logic [7:0] ctrl;
    logic [6:0] own_slave_addr;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic frozen;
    logic [7:0] rdata;
    logic irq;
    logic sda_out;
    logic sda_oe_n;
  } ibsf_state_t;
endpackage

// ==== ibsf_top.sv ====
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "ibsf_consts.svh"
module ibsf_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire ibsf_pkg::ibsf_bus_t bus,
  input wire logic serial_clock_line,
  input wire logic serial_data_line,
  input wire logic start_gen,
  input wire logic arb_loss,
  input wire logic drive_low,
  output logic [7:0] rdata,
  output logic bus_irq_request,
  output logic sda_out,
  output logic sda_oe_n
);
  ibsf_pkg::ibsf_state_t s;
  ibsf_pkg::ibsf_state_t next_s;
  logic scl_rise;
  logic sda_rise;
  logic sda_fall;
  logic start_det;
  logic stop_det;
  logic enable;
  logic disable_evt;
  logic exit_cmd;
  logic [7:0] addr_byte;
  // =====================================================
  // link edges
  assign enable = s.ctrl[`IBSF_CTRL_ENABLE];
  assign scl_rise = s.scl_sync[1] & ~s.scl_q;
  assign sda_rise = s.sda_sync[1] & ~s.sda_q;
  assign sda_fall = ~s.sda_sync[1] & s.sda_q;
  assign start_det = enable & s.scl_sync[1] & s.scl_q & sda_fall;
  assign stop_det = enable & s.scl_sync[1] & s.scl_q & sda_rise;
  assign disable_evt = bus.wr & (bus.addr == `IBSF_ADDR_CTRL) & enable
    & ~bus.wdata[`IBSF_CTRL_ENABLE];
  assign exit_cmd = bus.wr & (bus.addr == `IBSF_ADDR_CTRL) & bus.wdata[`IBSF_CTRL_EXIT];
  assign addr_byte = {s.shift[6:0], s.sda_sync[1]};
  // =====================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.scl_sync = {s.scl_sync[0], serial_clock_line};
    next_s.sda_sync = {s.sda_sync[0], serial_data_line};
    next_s.scl_q = s.scl_sync[1];
    next_s.sda_q = s.sda_sync[1];
    if (bus.wr) begin
      unique case (bus.addr)
        `IBSF_ADDR_CTRL: next_s.ctrl = bus.wdata & 8'h8C;
        `IBSF_ADDR_IRQ_MASK: next_s.irq_mask = bus.wdata[3:0];
        `IBSF_ADDR_SLAVE: next_s.own_slave_addr = bus.wdata[7:1];
        `IBSF_ADDR_IRQ_ST: next_s.irq_status = s.irq_status & ~bus.wdata[3:0];
        default: ;
      endcase
    end
    // status address writes fall to default
    if (s.ctrl[`IBSF_CTRL_WAKE] & bus.wr & (bus.addr == `IBSF_ADDR_CTRL)
        & ~bus.wdata[`IBSF_CTRL_WAKE]) begin
      next_s.frozen = 1'b1;
    end
    if (start_det | stop_det) begin
      next_s.frozen = 1'b0;
    end
    if (enable & ~s.frozen) begin
      if (scl_rise) begin
        next_s.shift = {s.shift[6:0], s.sda_sync[1]};
        next_s.bit_cnt = (s.bit_cnt == `IBSF_BIT_ACK) ? 4'h1 : s.bit_cnt + 4'h1;
        if (s.bit_cnt == `IBSF_BIT_ACK) begin
          next_s.status.ack_seen_flag = 1'b0;
          next_s.phase = ibsf_pkg::IBSF_DATA;
        end
        if (s.bit_cnt == `IBSF_BIT_ADDR - 4'h1 && s.phase == ibsf_pkg::IBSF_ADDR) begin
          if (addr_byte[7:4] == 4'h0 || addr_byte[7:4] == 4'hF) begin
            next_s.status.ext_code_flag = 1'b1;
          end
          if (addr_byte[7:1] == s.own_slave_addr) begin
            next_s.status.addr_match_flag = 1'b1;
            next_s.irq_status[`IBSF_EV_ADDR] = 1'b1;
          end
        end
        if (s.bit_cnt == `IBSF_BIT_ADDR && ~s.sda_sync[1]) begin
          next_s.status.ack_seen_flag = 1'b1;
        end
      end
      next_s.status.tx_state_flag = s.ctrl[`IBSF_CTRL_TX];
      if (start_gen) begin
        next_s.status.master_state_flag = 1'b1;
      end
      if (arb_loss) begin
        next_s.status.arb_lost_flag = 1'b1;
        next_s.status.master_state_flag = 1'b0;
        next_s.irq_status[`IBSF_EV_ARB] = 1'b1;
      end
      if (start_det) begin
        next_s.phase = ibsf_pkg::IBSF_ADDR;
        next_s.bit_cnt = 4'h0;
        next_s.status.start_seen_flag = 1'b1;
        next_s.status.stop_seen_flag = 1'b0;
        next_s.status.ext_code_flag = 1'b0;
        next_s.status.addr_match_flag = 1'b0;
        next_s.irq_status[`IBSF_EV_START] = 1'b1;
      end
      if (stop_det) begin
        next_s.phase = ibsf_pkg::IBSF_IDLE;
        next_s.status.stop_seen_flag = 1'b1;
        next_s.status.start_seen_flag = 1'b0;
        next_s.status.master_state_flag = 1'b0;
        next_s.status.ext_code_flag = 1'b0;
        next_s.status.addr_match_flag = 1'b0;
        next_s.status.ack_seen_flag = 1'b0;
        next_s.status.tx_state_flag = 1'b0;
        next_s.irq_status[`IBSF_EV_STOP] = 1'b1;
      end
    end else if (enable & (start_det | stop_det)) begin
      next_s.status.start_seen_flag = start_det;
      next_s.status.stop_seen_flag = stop_det;
      next_s.status.master_state_flag = 1'b0;
      next_s.status.ext_code_flag = 1'b0;
      next_s.status.addr_match_flag = 1'b0;
      next_s.status.ack_seen_flag = 1'b0;
      next_s.irq_status[`IBSF_EV_STOP] = stop_det | s.irq_status[`IBSF_EV_STOP];
      next_s.irq_status[`IBSF_EV_START] = start_det | s.irq_status[`IBSF_EV_START];
    end
    next_s.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `IBSF_ADDR_STATUS: next_s.rdata = s.status;
        `IBSF_ADDR_CTRL: next_s.rdata = s.ctrl;
        `IBSF_ADDR_IRQ_ST: next_s.rdata = {4'h0, s.irq_status};
        `IBSF_ADDR_IRQ_MASK: next_s.rdata = {4'h0, s.irq_mask};
        `IBSF_ADDR_SLAVE: next_s.rdata = {s.own_slave_addr, 1'b0};
        default: next_s.rdata = 8'h00;
      endcase
      if (bus.addr == `IBSF_ADDR_STATUS && !(enable & arb_loss)) begin
        next_s.status.arb_lost_flag = 1'b0;
      end
    end
    if (exit_cmd) begin
      next_s.status.master_state_flag = 1'b0;
      next_s.status.ext_code_flag = 1'b0;
      next_s.status.addr_match_flag = 1'b0;
      next_s.status.ack_seen_flag = 1'b0;
      next_s.status.tx_state_flag = 1'b0;
      next_s.phase = ibsf_pkg::IBSF_IDLE;
    end
    if (disable_evt) begin
      next_s.status = `IBSF_STATUS_RST;
      next_s.phase = ibsf_pkg::IBSF_IDLE;
      next_s.frozen = 1'b0;
    end
    next_s.irq = |(next_s.irq_status & s.irq_mask);
    // open drain: only ever pulls low
    next_s.sda_out = 1'b0;
    next_s.sda_oe_n = ~(next_s.status.tx_state_flag & drive_low);
  end
  // =====================================================
  // registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
      s.sda_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  assign rdata = s.rdata;
  assign bus_irq_request = s.irq;
  assign sda_out = s.sda_out;
  assign sda_oe_n = s.sda_oe_n;
  // =====================================================
  // checks
  AST_RESET_ZERO: assert property (@(posedge sys_clk) !rstn |=> s.status == 8'h00)
    else $error("status not zero after reset");
  AST_MASTER_SET: assert property (@(posedge sys_clk) disable iff (!rstn)
    enable && !s.frozen && start_gen && !arb_loss && !exit_cmd && !disable_evt && !stop_det
    |=> s.status.master_state_flag)
    else $error("master flag not set");
  AST_ARB_LOSS: assert property (@(posedge sys_clk) disable iff (!rstn)
    enable && !s.frozen && arb_loss && !disable_evt |=> s.status.arb_lost_flag
    && !s.status.master_state_flag)
    else $error("arbitration loss not recorded");
  AST_ARB_READ_CLR: assert property (@(posedge sys_clk) disable iff (!rstn)
    bus.rd && bus.addr == `IBSF_ADDR_STATUS && !arb_loss |=> !s.status.arb_lost_flag)
    else $error("lost flag not cleared by read");
  AST_STOP_CLR: assert property (@(posedge sys_clk) disable iff (!rstn)
    stop_det && !disable_evt |=> s.status.stop_seen_flag && !s.status.master_state_flag
    && !s.status.addr_match_flag && !s.status.ext_code_flag)
    else $error("stop did not clear flags");
  AST_START_CLR: assert property (@(posedge sys_clk) disable iff (!rstn)
    start_det && !disable_evt |=> s.status.start_seen_flag && !s.status.ext_code_flag
    && !s.status.addr_match_flag)
    else $error("start did not clear flags");
  AST_DISABLE: assert property (@(posedge sys_clk) disable iff (!rstn)
    disable_evt |=> s.status == 8'h00)
    else $error("disable did not clear status");
  AST_READ_DATA: assert property (@(posedge sys_clk) disable iff (!rstn)
    bus.rd && bus.addr == `IBSF_ADDR_STATUS |=> rdata == $past(s.status))
    else $error("status read data wrong");
  AST_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn)
    bus.wr && bus.addr == `IBSF_ADDR_STATUS && !enable |=> $stable(s.status))
    else $error("status changed by write");
  AST_FROZEN: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.frozen && !start_det && !stop_det && !exit_cmd && !disable_evt
    && !(bus.rd && bus.addr == `IBSF_ADDR_STATUS) |=> $stable(s.status))
    else $error("status updated while frozen");
  COV_START: cover property (@(posedge sys_clk) start_det);
  COV_MATCH: cover property (@(posedge sys_clk) $rose(s.status.addr_match_flag));
  COV_ARB: cover property (@(posedge sys_clk) $rose(s.status.arb_lost_flag));
  COV_IRQ: cover property (@(posedge sys_clk) $rose(bus_irq_request));
endmodule // ibsf_top

// ==== ibsf_far_end.sv ====
`timescale 1ns/1ps
module ibsf_far_end (
  output logic scl_drv,
  output logic sda_drv
);
  // ==========================================
  // far master on the wire, 200 ns bit period
  // released lines float to the pull-up level
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic start_cond();
    sda_drv = 1'b1;
    #50 scl_drv = 1'b1;
    #50 sda_drv = 1'b0;
    #100 scl_drv = 1'b0;
  endtask
  task automatic bit_out(input logic b);
    #25 sda_drv = b;
    #25 scl_drv = 1'b1;
    #100 scl_drv = 1'b0;
    #50;
  endtask
  // eight data clocks, then the acknowledge on the 9th
  task automatic send_byte(input logic [7:0] v, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(v[i]);
    end
    bit_out(!ack);
  endtask
  task automatic stop_cond();
    #25 sda_drv = 1'b0;
    #25 scl_drv = 1'b1;
    #50 sda_drv = 1'b1;
    #100;
  endtask
endmodule // ibsf_far_end

// ==== i2c_status_flags_bench.sv ====
`timescale 1ns/1ps
`include "ibsf_consts.svh"
module i2c_status_flags_bench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  ibsf_pkg::ibsf_bus_t bus = '0;
  logic start_gen = 1'b0;
  logic arb_loss = 1'b0;
  logic drive_low = 1'b0;
  logic [7:0] rdata;
  logic bus_irq_request, sda_out, sda_oe_n, scl_drv, sda_drv, sda_wire;
  int failures = 0;
  int tests_run = 0;
  always #12.5 sys_clk = ~sys_clk;
  assign sda_wire = sda_drv & (sda_oe_n | sda_out);
  ibsf_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .bus(bus), .serial_clock_line(scl_drv),
    .serial_data_line(sda_wire), .start_gen(start_gen), .arb_loss(arb_loss),
    .drive_low(drive_low), .rdata(rdata), .bus_irq_request(bus_irq_request),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  ibsf_far_end i_far (.scl_drv(scl_drv), .sda_drv(sda_drv));
  // ==========================================
  // helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= {a, d, 2'b10};
    @(posedge sys_clk);
    bus <= '0;
  endtask
  // single byte reads only, while the far end holds the serial lines still
  task automatic rd(input logic [19:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    bus <= {a, 8'h00, 2'b01};
    @(posedge sys_clk);
    bus <= '0;
    #1 v = rdata;
  endtask
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    rd(`IBSF_ADDR_STATUS, v);
    check("bus_status", v & m, e);
  endtask
  task automatic pulse(input logic arb);
    @(posedge sys_clk);
    if (arb) arb_loss <= 1'b1;
    else start_gen <= 1'b1;
    @(posedge sys_clk);
    arb_loss <= 1'b0;
    start_gen <= 1'b0;
  endtask
  task automatic settle();
    repeat (10) @(posedge sys_clk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [7:0] v;
    st(8'hFF, `IBSF_STATUS_RST);
    rd(20'hFFF70, v);
    check("unmapped", v, 8'h00);
    wr(`IBSF_ADDR_STATUS, 8'hFF);
    st(8'hFF, 8'h00);
  endtask
  task automatic t_detect();
    logic [7:0] codes [2] = '{8'h0E, 8'hF0};
    wr(`IBSF_ADDR_CTRL, 8'h80);
    wr(`IBSF_ADDR_SLAVE, 8'h54);
    i_far.start_cond();
    settle();
    st(8'h03, 8'h02);
    check("irq masked", {7'h00, bus_irq_request}, 8'h00);
    wr(`IBSF_ADDR_IRQ_MASK, 8'h01);
    settle();
    check("irq", {7'h00, bus_irq_request}, 8'h01);
    wr(`IBSF_ADDR_IRQ_ST, 8'h01);
    settle();
    check("irq cleared", {7'h00, bus_irq_request}, 8'h00);
    i_far.send_byte(8'h54, 1'b1);
    settle();
    st(8'h34, 8'h14);
    for (int i = 0; i < 2; i++) begin
      i_far.start_cond();
      i_far.send_byte(codes[i], 1'b1);
      settle();
      st(8'h34, 8'h24);
    end
    i_far.stop_cond();
    settle();
    st(8'h35, 8'h01);
  endtask
  task automatic t_master();
    pulse(1'b0);
    st(8'hC0, 8'h80);
    pulse(1'b1);
    st(8'hC0, 8'h40);
    st(8'h40, 8'h00);
    pulse(1'b0);
    wr(`IBSF_ADDR_CTRL, 8'h81);
    st(8'h80, 8'h00);
    pulse(1'b0);
    pulse(1'b1);
    wr(`IBSF_ADDR_CTRL, 8'h00);
    st(8'hFF, 8'h00);
  endtask
  task automatic t_freeze();
    wr(`IBSF_ADDR_CTRL, 8'h88);
    wr(`IBSF_ADDR_CTRL, 8'h80);
    pulse(1'b0);
    st(8'h80, 8'h00);
    i_far.start_cond();
    settle();
    st(8'h02, 8'h02);
    pulse(1'b0);
    st(8'h80, 8'h80);
    i_far.stop_cond();
  endtask
  task automatic t_tx();
    wr(`IBSF_ADDR_CTRL, 8'h84);
    drive_low <= 1'b1;
    st(8'h08, 8'h08);
    check("sda_oe_n", {7'h00, sda_oe_n}, 8'h00);
    wr(`IBSF_ADDR_CTRL, 8'h80);
    settle();
    check("sda_oe_n rx", {7'h00, sda_oe_n}, 8'h01);
    drive_low <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_detect();
    t_master();
    t_freeze();
    t_tx();
    end_sim();
  end
  initial begin
    #2000000;
    failures++;
    $display("unexpected timeout");
    end_sim();
  end
endmodule // i2c_status_flags_bench
